// ===== char_lcd_command_core.sv
// Instruction decoder, address counter and display scan of the display core
// Overview of operation
// - Pattern words 0x30..0x3F bits 0..4 drive icons, 0x30 highest group.
// - Icon words overlap user glyphs 6/7 and 14/15; fewer glyphs remain.
// - Pattern memory is cleared only by software initialization.
// - Refresh reads use a port separate from host access; no flicker.
// - Forty row bits shift in, then latch to segments when complete.
// - Selected commons get select level, remaining of 33 get non-select.
// - Cursor follows the counter, even at pattern addresses; blink is not scanned.
// - Busy stays set through the power-on initialization interval.
// - Reset low over 1.2 ms starts a sequence, then busy 10 ms.
// - Reset defaults to forty characters on two lines.
// - Select and direction choose command, status, data write, data read.
// - Status returns busy on bit 7; host waits until it clears.
// - Commands decode by their highest set bit.
// - Long, shift/read and short execution times hold busy.
// - Clear fills text with spaces, counter zero, forces increment.
// - Home zeroes counter and display shift, keeps text memory.
// - Address commands load counter and select target memory.
// - Entry mode stores direction and display-shift-on-write flag.
// - Display control stores display, cursor and blink enables.
// - Shift moves cursor or display one position, text untouched.
// - Function set stores bus width, line count, glyph count bits.
// - Four-bit mode moves each byte as two nibble transfers.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
module char_lcd_command_core #(
   parameter int unsigned INIT_CYCLES   = char_lcd_pkg::CYC_INIT,
   parameter int unsigned RSTLOW_CYCLES = char_lcd_pkg::CYC_RSTLOW,
   parameter int unsigned LONG_CYCLES   = char_lcd_pkg::CYC_LONG
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Display reset pin, active low
   input  wire logic        panel_reset_n,
   // Panel drive
   output logic [39:0]      segment_out,
   output logic [32:0]      common_select,
   output logic [79:0]      icon_out,
   output logic             busy_indicator
);
   // Address phase capture
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [11:0] addr_r;
   wire         addr_ok = hsel & hready & htrans[1];
   wire  [11:0] a_eff   = addr_r;

   // Core state
   char_lcd_pkg::state_t st_r;
   logic [6:0]  address_counter_r;
   logic        target_pat_r;
   logic        inc_r;
   logic        shift_on_r;
   logic        disp_on_r;
   logic        cursor_on_r;
   logic        blink_on_r;
   logic        bus_width_r;
   logic        lines4_r;
   logic        glyph_count_hi_r;
   logic        glyph_count_lo_r;
   logic [6:0]  disp_shift_r;
   logic [23:0] busy_cnt_r;
   logic [7:0]  command_latch_r;
   logic [7:0]  transfer_latch_r;
   logic [7:0]  read_latch_r;
   logic        nib_hi_pend_r;
   logic [3:0]  nib_hold_r;
   logic        nib_rd_lo_r;
   logic [6:0]  fill_idx_r;
   logic        pat_fill_r;
   logic [7:0]  text_mem [0:char_lcd_pkg::TEXT_DEPTH-1];
   logic [7:0]  pat_mem  [0:char_lcd_pkg::PAT_DEPTH-1];

   // Reset pin synchroniser and low-time filter
   logic        prst_s1_r;
   logic        prst_s2_r;
   logic [19:0] prst_low_r;
   logic        prst_armed_r;

   // Scan side
   logic [6:0]  scan_col_r;
   logic [5:0]  scan_bit_r;
   logic [39:0] shreg_r;
   logic [39:0] seg_r;
   logic [4:0]  scan_row_r;
   logic [79:0] icon_r;
   logic [3:0]  icon_idx_r;

   wire busy = (st_r != char_lcd_pkg::ST_IDLE);

   // Host write of the control word
   wire wr_ctrl  = wr_pend_r & (a_eff == char_lcd_pkg::ADDR_CTRL);
   wire go       = wr_ctrl & hwdata[char_lcd_pkg::CTRL_GO_BIT];
   wire sel_data = hwdata[char_lcd_pkg::CTRL_SEL_BIT];
   wire dir_rd   = hwdata[char_lcd_pkg::CTRL_RD_BIT];
   wire swrst    = wr_ctrl & hwdata[char_lcd_pkg::CTRL_SWRST_BIT];
   wire [7:0] wbyte = hwdata[7:0];

   // nibble assembly: upper nibble taken first
   wire       nib_mode  = ~bus_width_r;
   wire       nib_first = nib_mode & go & ~dir_rd & ~nib_hi_pend_r;
   wire [7:0] full_byte = nib_mode ? {nib_hold_r, wbyte[7:4]} : wbyte;
   wire       byte_go   = go & ~dir_rd & ~nib_first;
   // Status reads are always allowed; others only when idle
   wire       do_cmd    = byte_go & ~sel_data & ~busy;
   wire       do_wdata  = byte_go & sel_data & ~busy;
   wire       rd_go     = go & dir_rd;
   wire       do_rdata  = rd_go & sel_data & ~busy & ~nib_rd_lo_r;

   function automatic char_lcd_pkg::op_t decode(input logic [7:0] c);
      if (c[7])      return char_lcd_pkg::OP_TXT_ADDR;
      else if (c[6]) return char_lcd_pkg::OP_PAT_ADDR;
      else if (c[5]) return char_lcd_pkg::OP_FUNC;
      else if (c[4]) return char_lcd_pkg::OP_SHIFT;
      else if (c[3]) return char_lcd_pkg::OP_DISP;
      else if (c[2]) return char_lcd_pkg::OP_ENTRY;
      else if (c[1]) return char_lcd_pkg::OP_HOME;
      else if (c[0]) return char_lcd_pkg::OP_CLEAR;
      else           return char_lcd_pkg::OP_TEST;
   endfunction : decode

   function automatic logic [6:0] step(input logic [6:0] v, input logic up);
      return up ? v + 7'h01 : v - 7'h01;
   endfunction : step

   wire char_lcd_pkg::op_t op = decode(full_byte);

   wire [23:0] exec_cyc =
      (op == char_lcd_pkg::OP_CLEAR || op == char_lcd_pkg::OP_HOME) ?
         24'(LONG_CYCLES) :
      (op == char_lcd_pkg::OP_SHIFT) ? 24'(char_lcd_pkg::CYC_SHIFT) :
         24'(char_lcd_pkg::CYC_SHORT);
   wire [23:0] load_cyc = do_cmd   ? exec_cyc :
                          do_rdata ? 24'(char_lcd_pkg::CYC_SHIFT) :
                                     24'(char_lcd_pkg::CYC_SHORT);

   wire prst_fire = prst_armed_r & prst_s2_r;

   // Status byte and its nibble split
   wire [7:0] status_byte = {busy, address_counter_r};
   wire [7:0] rd_byte     = sel_data ? read_latch_r : status_byte;

   // cursor display position follows the counter
   wire [6:0] cursor_pos  = address_counter_r - disp_shift_r;

   // Host access timing and refresh use separate memory ports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 12'h000;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         rd_pend_r <= addr_ok & ~hwrite;
         if (addr_ok)
            addr_r <= haddr[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prst_s1_r    <= 1'b1;
         prst_s2_r    <= 1'b1;
         prst_low_r   <= 20'h00000;
         prst_armed_r <= 1'b0;
      end else begin
         prst_s1_r <= panel_reset_n;
         prst_s2_r <= prst_s1_r;
         if (prst_s2_r)
            prst_low_r <= 20'h00000;
         else if (prst_low_r != 20'(RSTLOW_CYCLES))
            prst_low_r <= prst_low_r + 20'h00001;
         // Low must last strictly longer than the minimum
         prst_armed_r <= ~prst_s2_r & (prst_low_r == 20'(RSTLOW_CYCLES))
                         | (prst_armed_r & ~prst_s2_r);
      end
   end

   // Command engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r              <= char_lcd_pkg::ST_INIT;
         busy_cnt_r        <= 24'(INIT_CYCLES);
         address_counter_r <= char_lcd_pkg::AC_RST;
         target_pat_r      <= 1'b0;
         inc_r             <= 1'b1;
         shift_on_r        <= 1'b0;
         disp_on_r         <= 1'b0;
         cursor_on_r       <= 1'b0;
         blink_on_r        <= 1'b0;
         bus_width_r       <= char_lcd_pkg::BUS8_RST;
         lines4_r          <= char_lcd_pkg::LINES4_RST;
         glyph_count_hi_r  <= char_lcd_pkg::GLYPH_RST[1];
         glyph_count_lo_r  <= char_lcd_pkg::GLYPH_RST[0];
         disp_shift_r      <= 7'h00;
         command_latch_r   <= 8'h00;
         transfer_latch_r  <= 8'h00;
         read_latch_r      <= 8'h00;
         nib_hi_pend_r     <= 1'b0;
         nib_hold_r        <= 4'h0;
         nib_rd_lo_r       <= 1'b0;
         fill_idx_r        <= 7'h00;
         pat_fill_r        <= 1'b0;
      end else if (prst_fire | swrst) begin
         st_r             <= char_lcd_pkg::ST_FILL;
         fill_idx_r       <= 7'h00;
         pat_fill_r       <= swrst;
         busy_cnt_r       <= 24'(INIT_CYCLES);
         address_counter_r <= char_lcd_pkg::AC_RST;
         target_pat_r     <= 1'b0;
         inc_r            <= 1'b1;
         shift_on_r       <= 1'b0;
         disp_on_r        <= 1'b0;
         cursor_on_r      <= 1'b0;
         blink_on_r       <= 1'b0;
         bus_width_r      <= char_lcd_pkg::BUS8_RST;
         lines4_r         <= char_lcd_pkg::LINES4_RST;
         glyph_count_hi_r <= char_lcd_pkg::GLYPH_RST[1];
         glyph_count_lo_r <= char_lcd_pkg::GLYPH_RST[0];
         disp_shift_r     <= 7'h00;
         nib_hi_pend_r    <= 1'b0;
         nib_rd_lo_r      <= 1'b0;
      end else begin
         if (nib_first) begin
            nib_hold_r    <= wbyte[7:4];
            nib_hi_pend_r <= 1'b1;
         end else if (byte_go)
            nib_hi_pend_r <= 1'b0;
         if (rd_go & nib_mode)
            nib_rd_lo_r <= ~nib_rd_lo_r;
         unique case (st_r)
            char_lcd_pkg::ST_INIT, char_lcd_pkg::ST_BUSY: begin
               if (busy_cnt_r <= 24'h000001)
                  st_r <= char_lcd_pkg::ST_IDLE;
               busy_cnt_r <= busy_cnt_r - 24'h000001;
            end
            char_lcd_pkg::ST_FILL: begin
               // Space fill one location per cycle, timer runs alongside
               fill_idx_r <= fill_idx_r + 7'h01;
               busy_cnt_r <= busy_cnt_r - 24'h000001;
               if (fill_idx_r == 7'h7F) begin
                  st_r       <= char_lcd_pkg::ST_BUSY;
                  pat_fill_r <= 1'b0;
               end
            end
            char_lcd_pkg::ST_IDLE: begin
               if (do_cmd | do_wdata | do_rdata) begin
                  st_r       <= char_lcd_pkg::ST_BUSY;
                  busy_cnt_r <= load_cyc;
               end
               if (do_cmd) begin
                  command_latch_r <= full_byte;
                  unique case (op)
                     char_lcd_pkg::OP_TEST: ;
                     char_lcd_pkg::OP_CLEAR: begin
                        st_r              <= char_lcd_pkg::ST_FILL;
                        fill_idx_r        <= 7'h00;
                        address_counter_r <= 7'h00;
                        target_pat_r      <= 1'b0;
                        inc_r             <= 1'b1;
                        disp_shift_r      <= 7'h00;
                     end
                     char_lcd_pkg::OP_HOME: begin
                        address_counter_r <= 7'h00;
                        target_pat_r      <= 1'b0;
                        disp_shift_r      <= 7'h00;
                     end
                     char_lcd_pkg::OP_ENTRY: begin
                        inc_r      <= full_byte[1];
                        shift_on_r <= full_byte[0];
                     end
                     char_lcd_pkg::OP_DISP: begin
                        disp_on_r   <= full_byte[2];
                        cursor_on_r <= full_byte[1];
                        blink_on_r  <= full_byte[0];
                     end
                     char_lcd_pkg::OP_SHIFT: begin
                        if (full_byte[3])
                           disp_shift_r <= step(disp_shift_r,
                                                full_byte[2]);
                        else
                           address_counter_r <= step(address_counter_r,
                                                     full_byte[2]);
                     end
                     char_lcd_pkg::OP_FUNC: begin
                        bus_width_r      <= full_byte[4];
                        lines4_r         <= full_byte[3];
                        glyph_count_hi_r <= full_byte[1];
                        glyph_count_lo_r <= full_byte[0];
                     end
                     char_lcd_pkg::OP_PAT_ADDR: begin
                        address_counter_r <= {1'b0, full_byte[5:0]};
                        target_pat_r      <= 1'b1;
                     end
                     char_lcd_pkg::OP_TXT_ADDR: begin
                        address_counter_r <= full_byte[6:0];
                        target_pat_r      <= 1'b0;
                     end
                     default: ;
                  endcase
               end
               if (do_wdata | do_rdata) begin
                  address_counter_r <= step(address_counter_r, inc_r);
                  if (do_wdata & shift_on_r & ~target_pat_r)
                     disp_shift_r <= step(disp_shift_r, ~inc_r);
               end
               if (do_wdata)
                  transfer_latch_r <= full_byte;
               if (do_rdata)
                  read_latch_r <= target_pat_r ?
                     pat_mem[address_counter_r[5:0]] :
                     text_mem[address_counter_r];
            end
            default: st_r <= char_lcd_pkg::ST_IDLE;
         endcase
      end
   end

   // Host port of the memories, separate from the scan read port
   always_ff @(posedge hclk) begin
      if (st_r == char_lcd_pkg::ST_FILL) begin
         text_mem[fill_idx_r] <= char_lcd_pkg::SPACE_CODE;
         if (pat_fill_r)
            pat_mem[fill_idx_r[5:0]] <= 8'h00;
      end else if (do_wdata & ~(prst_fire | swrst)) begin
         if (target_pat_r)
            pat_mem[address_counter_r[5:0]] <= full_byte;
         else
            text_mem[address_counter_r] <= full_byte;
      end
   end

   // refresh scan: own counters, own read port
   wire [6:0] scan_addr = scan_col_r + disp_shift_r
                        + {scan_row_r[4:3], 5'h00};
   wire [7:0] scan_code = text_mem[scan_addr];
   wire       scan_dot  = disp_on_r & (scan_code[4:0] != 5'h00)
                        | (cursor_on_r & (scan_addr == cursor_pos)
                           & (scan_row_r[2:0] == 3'h7));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_col_r <= 7'h00;
         scan_bit_r <= 6'h00;
         scan_row_r <= 5'h00;
         shreg_r    <= 40'h0000000000;
         seg_r      <= 40'h0000000000;
      end else begin
         shreg_r <= {shreg_r[38:0], scan_dot};
         if (scan_bit_r == 6'(char_lcd_pkg::ROW_BITS - 1)) begin
            scan_bit_r <= 6'h00;
            scan_col_r <= 7'h00;
            seg_r      <= {shreg_r[38:0], scan_dot};
            scan_row_r <= scan_row_r + 5'h01;
         end else begin
            scan_bit_r <= scan_bit_r + 6'h01;
            scan_col_r <= scan_col_r + 7'h01;
         end
      end
   end

   // icon map: word 0x30 feeds the top five icons, one word per cycle
   wire [7:0] icon_word = pat_mem[{2'b11, icon_idx_r}];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         icon_idx_r <= 4'h0;
         icon_r     <= 80'h0;
      end else begin
         icon_idx_r <= icon_idx_r + 4'h1;
         icon_r[7'd75 - 7'(icon_idx_r) * 7'd5 +: 5] <=
            disp_on_r ? icon_word[4:0] : 5'h00;
      end
   end

   wire [4:0] rows_used = lines4_r ? 5'd31 : 5'd15;
   wire [4:0] cur_row   = scan_row_r & rows_used;
   always_comb begin
      common_select = 33'h0;
      common_select[cur_row] = disp_on_r;
      common_select[32] = disp_on_r;
   end

   // Register read mux
   wire [31:0] rd_mux =
      (a_eff == char_lcd_pkg::ADDR_CTRL)   ? {24'h0, nib_mode ?
         (nib_rd_lo_r ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0}) :
         rd_byte} :
      (a_eff == char_lcd_pkg::ADDR_STATUS) ? {16'h0, command_latch_r,
                                              status_byte} :
      (a_eff == char_lcd_pkg::ADDR_CONFIG) ? {22'h0, target_pat_r, inc_r,
         shift_on_r, disp_on_r, cursor_on_r, blink_on_r, bus_width_r,
         lines4_r, glyph_count_hi_r, glyph_count_lo_r} :
      (a_eff == char_lcd_pkg::ADDR_CURSOR) ? {17'h0, disp_shift_r,
                                              1'b0, cursor_pos} :
      (a_eff == char_lcd_pkg::ADDR_ICON_HI) ? {16'h0, icon_r[79:64]} :
      (a_eff == char_lcd_pkg::ADDR_ICON_LO) ? icon_r[31:0] :
      (a_eff == char_lcd_pkg::ADDR_LATCH)  ? {24'h0, transfer_latch_r} :
      (a_eff == char_lcd_pkg::ADDR_COMMON) ? {31'h0, blink_on_r} :
                                             32'h0;

   // Zero-wait slave, always OKAY
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = rd_pend_r ? rd_mux : 32'h0;
   assign segment_out    = seg_r;
   assign icon_out       = icon_r;
   assign busy_indicator = busy;
endmodule : char_lcd_command_core
`default_nettype wire

// ===== char_lcd_pkg.sv
// Constants and types shared by the character display command core
`default_nettype none
package char_lcd_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned OSC_HZ          = 330_000;
   // Execution, initialization and reset-low times at the nominal oscillator, in ns
   localparam int unsigned T_LONG_NS       = 1_480_000;
   localparam int unsigned T_SHIFT_NS      = 45_000;
   localparam int unsigned T_SHORT_NS      = 30_000;
   localparam int unsigned T_INIT_NS       = 10_000_000;
   localparam int unsigned T_RSTLOW_NS     = 1_200_000;
   localparam int unsigned NS_PER_S        = 1_000_000_000;
   localparam int unsigned CYC_LONG  = (T_LONG_NS  * 100 + 999) / 1000;
   localparam int unsigned CYC_SHIFT = (T_SHIFT_NS * 100 + 999) / 1000;
   localparam int unsigned CYC_SHORT = (T_SHORT_NS * 100 + 999) / 1000;
   localparam int unsigned CYC_INIT  = (T_INIT_NS  * 100 + 999) / 1000;
   localparam int unsigned CYC_RSTLOW = (T_RSTLOW_NS * 100) / 1000;
   // Register map, byte addresses
   localparam logic [11:0] ADDR_CTRL       = 12'h000;
   localparam logic [11:0] ADDR_STATUS     = 12'h004;
   localparam logic [11:0] ADDR_CONFIG     = 12'h008;
   localparam logic [11:0] ADDR_CURSOR     = 12'h00C;
   localparam logic [11:0] ADDR_ICON_HI    = 12'h010;
   localparam logic [11:0] ADDR_ICON_LO    = 12'h014;
   localparam logic [11:0] ADDR_LATCH      = 12'h018;
   localparam logic [11:0] ADDR_COMMON     = 12'h01C;
   // Control register fields
   localparam int unsigned CTRL_DATA_LSB   = 0;
   localparam int unsigned CTRL_SEL_BIT    = 8;
   localparam int unsigned CTRL_RD_BIT     = 9;
   localparam int unsigned CTRL_GO_BIT     = 10;
   localparam int unsigned CTRL_SWRST_BIT  = 11;
   // Reset values, fill and icon codes, memory and panel sizes
   localparam logic [6:0] AC_RST           = 7'h00;
   localparam logic       BUS8_RST         = 1'b1;
   localparam logic       LINES4_RST       = 1'b0;
   localparam logic [1:0] GLYPH_RST        = 2'b11;
   localparam logic [7:0] SPACE_CODE       = 8'h20;
   localparam logic [5:0] ICON_BASE        = 6'h30;
   localparam int unsigned TEXT_DEPTH      = 128;
   localparam int unsigned PAT_DEPTH       = 64;
   localparam int unsigned ROW_BITS        = 40;
   localparam int unsigned N_COMMON        = 33;
   localparam int unsigned N_ICON          = 80;

   typedef enum logic [3:0] {
      OP_NONE, OP_TEST, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP, OP_SHIFT,
      OP_FUNC, OP_PAT_ADDR, OP_TXT_ADDR
   } op_t;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY, ST_FILL} state_t;
endpackage : char_lcd_pkg
`default_nettype wire

// ===== char_lcd_props.sv
// Checker for bus timing and busy behaviour of the display command core
`default_nettype none
module char_lcd_props #(
   parameter int unsigned INIT_CYCLES   = 200,
   parameter int unsigned RSTLOW_CYCLES = 20,
   parameter int unsigned LONG_CYCLES   = 300
) (
   // Clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Panel side
   input wire logic        panel_reset_n,
   input wire logic        busy_indicator
);
   logic        rd_q;
   logic        rd_st_q;
   logic        wr_q;
   logic [15:0] busy_cnt_r;
   logic [15:0] low_cnt_r;
   wire         take = hsel & hready & htrans[1];
   wire  [11:0] a12  = haddr[11:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rd_q, rd_st_q, wr_q} <= 3'h0;
         busy_cnt_r <= 16'h0;
         low_cnt_r  <= 16'h0;
      end else begin
         rd_q    <= take & !hwrite;
         rd_st_q <= take & !hwrite & (a12 == char_lcd_pkg::ADDR_STATUS);
         wr_q    <= take & hwrite & (a12 == char_lcd_pkg::ADDR_CTRL);
         busy_cnt_r <= busy_indicator ? busy_cnt_r + 16'h1 : 16'h0;
         low_cnt_r  <= panel_reset_n ? 16'h0 : low_cnt_r + 16'h1;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_init_busy: assert property ($rose(hresetn) |-> busy_indicator[*8])
      else $error("busy dropped early after reset");
   chk_status_busy: assert property (rd_st_q |-> hrdata[7] == busy_indicator)
      else $error("status bit 7 differs from busy");
   chk_cmd_busy: assert property (wr_q && hwdata[10] && !hwdata[11]
      && (hwdata[8] || !hwdata[9]) && !busy_indicator |-> ##[1:2] busy_indicator)
      else $error("accepted command did not raise busy");
   chk_busy_hold: assert property ($rose(busy_indicator) |-> busy_indicator[*8])
      else $error("busy pulse too short");
   chk_busy_bound: assert property (busy_cnt_r <= 16'd5000)
      else $error("busy held too long");
   chk_pin_busy: assert property ($rose(panel_reset_n)
      && low_cnt_r > RSTLOW_CYCLES + 4 |-> ##[1:4] busy_indicator[*8])
      else $error("pin reset did not hold busy");
   chk_zero_wait: assert property (hreadyout && !hresp)
      else $error("wait state or error response");
   chk_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data outside read data phase");
endmodule : char_lcd_props
bind char_lcd_command_core char_lcd_props #(.INIT_CYCLES(INIT_CYCLES),
   .RSTLOW_CYCLES(RSTLOW_CYCLES), .LONG_CYCLES(LONG_CYCLES)) props_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .panel_reset_n(panel_reset_n), .busy_indicator(busy_indicator));
`default_nettype wire

// ===== reset_pin_model.sv
// Host-side model driving the display reset pin
`default_nettype none
module reset_pin_model (
   // Clock
   input  wire logic hclk,
   // Reset pin, active low
   output logic      panel_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial panel_reset_n = 1'b1;
   // Low must outlast the threshold or no sequence starts
   task automatic pulse(input int unsigned n);
      panel_reset_n <= 1'b0;
      repeat (n) @(posedge hclk);
      panel_reset_n <= 1'b1;
      @(posedge hclk);
   endtask : pulse
endmodule : reset_pin_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the display command core
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy_indicator;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans;
   logic [39:0] segment_out;
   logic [32:0] common_select;
   logic [79:0] icon_out;
   wire logic   panel_reset_n;
   int          failures, samples_checked, cycles;
   // Short counts keep the run brief
   char_lcd_command_core #(.INIT_CYCLES(200), .RSTLOW_CYCLES(20),
      .LONG_CYCLES(300)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .panel_reset_n(panel_reset_n),
      .segment_out(segment_out), .common_select(common_select),
      .icon_out(icon_out), .busy_indicator(busy_indicator));
   reset_pin_model pin_u (.hclk(hclk), .panel_reset_n(panel_reset_n));
   task automatic end_of_test();
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Sampled just before the edge so registered updates never race
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      logic rdy;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      hwrite <= w;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         @(posedge hclk);
      end while (!rdy);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         rd  = hrdata;
         @(posedge hclk);
      end while (!rdy);
   endtask : bus
   task automatic wait_idle();
      do bus(1'b0, char_lcd_pkg::ADDR_STATUS, 32'h0, v);
      while (v[7] !== 1'b0);
   endtask : wait_idle
   // Never sends the all-zero test code
   task automatic cmd(input logic sel, input logic [7:0] b, input logic wt);
      bus(1'b1, char_lcd_pkg::ADDR_CTRL, {21'h0, 2'h2, sel, b}, v);
      if (wt)
         wait_idle();
   endtask : cmd
   task automatic ac_is(input logic [6:0] exp);
      bus(1'b0, char_lcd_pkg::ADDR_STATUS, 32'h0, v);
      check({25'h0, v[6:0]}, {25'h0, exp});
   endtask : ac_is
   task automatic cfg_is(input logic [9:0] exp);
      bus(1'b0, char_lcd_pkg::ADDR_CONFIG, 32'h0, v);
      check({22'h0, v[9:0]}, {22'h0, exp});
   endtask : cfg_is
   task automatic s_reset();
      bus(1'b0, char_lcd_pkg::ADDR_STATUS, 32'h0, v);
      check({31'h0, v[7]}, 32'h1);
      wait_idle();
      cfg_is(10'h10B);
      cmd(1'b0, 8'h33, 1'b1);
   endtask : s_reset
   task automatic s_commands();
      cmd(1'b0, 8'h85, 1'b1);
      ac_is(7'h05);
      cmd(1'b0, 8'h04, 1'b1);
      cfg_is(10'h00B);
      cmd(1'b0, 8'h0F, 1'b1);
      cfg_is(10'h07B);
      cmd(1'b0, 8'h14, 1'b1);
      ac_is(7'h06);
      cmd(1'b0, 8'h18, 1'b1);
      ac_is(7'h06);
      cmd(1'b0, 8'h01, 1'b1);
      ac_is(7'h00);
      cfg_is(10'h17B);
      cmd(1'b0, 8'h1C, 1'b1);
      cmd(1'b0, 8'h02, 1'b1);
      bus(1'b0, char_lcd_pkg::ADDR_CURSOR, 32'h0, v);
      check({25'h0, v[14:8]}, 32'h0);
   endtask : s_commands
   task automatic s_icon_refused();
      cmd(1'b0, 8'h70, 1'b1);
      cfg_is(10'h37B);
      cmd(1'b1, 8'h1F, 1'b1);
      check({27'h0, icon_out[79:75]}, 32'h1F);
      check({31'h0, common_select[32]}, 32'h1);
      ac_is(7'h31);
      cmd(1'b0, 8'h85, 1'b0);
      cmd(1'b0, 8'hC0, 1'b1);
      ac_is(7'h05);
      bus(1'b0, 12'h100, 32'h0, v);
      check(v, 32'h0);
   endtask : s_icon_refused
   task automatic s_pin_reset();
      pin_u.pulse(25);
      repeat (6) @(posedge hclk);
      bus(1'b0, char_lcd_pkg::ADDR_STATUS, 32'h0, v);
      check({31'h0, v[7]}, 32'h1);
      wait_idle();
      cfg_is(10'h10B);
      check({24'h0, segment_out[39:32]} | segment_out[31:0], 32'h0);
      cmd(1'b0, 8'h33, 1'b1);
   endtask : s_pin_reset
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {failures, samples_checked, cycles} = '0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset();
      s_commands();
      s_icon_refused();
      s_pin_reset();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
